//--- rtl/bfc_pkg.sv
// Package for the bulk-erase flash host controller.
// Assumes one 100 MHz clock domain; used by rtl/bfc_host.sv.
package bfc_pkg;

  // ---------------------------------------------------------------
  // Command codes written to the flash command register; erased and zero data bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'ha0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_VERIFY = 8'hc0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // Timing constants, retry limits and widths
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_PULSE_NS = 10000000;
  localparam int PROG_PULSE_NS = 10000;
  localparam int ERASE_PULSE_CYC = (ERASE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_PULSE_CYC = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = 4;
  localparam int MAX_ERASE_TRIES = 1000;
  localparam int MAX_PROG_TRIES = 25;
  localparam int TMR_W = 24;
  localparam int ADDR_W = 17;

  // ---------------------------------------------------------------
  // User request and answer carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE, OP_IDENT} bfc_op_t;

  typedef struct packed {
    bfc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } bfc_req_t;

  typedef struct packed {
    logic ok;
    logic fail;
    logic [7:0] data;
  } bfc_rsp_t;

  // Pin group toward the flash
  typedef struct packed {
    logic chip_sel_n;
    logic out_gate_n;
    logic wr_strobe_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
    logic id_hv_en;
    logic prog_supply_high_level;
  } bfc_pins_t;

endpackage : bfc_pkg

//--- rtl/bfc_host.sv
// Host controller that drives a bulk-erase parallel flash through its pins.
// Assumes the flash data bus input is sampled synchronously to clk and that
// bus cycles of STROBE_CYC clocks meet the device access times.
// Summary of operation
// - Erase: two erase writes then verify writes
// - Program whole array to zero before erasing
// - Wait 10 ms before erase-verify
// - Verify write carries address; compare FFh
// - Step erase-verify through every address
// - Failed byte repeats erase, 1000 max
// - Program: setup, address/data write, verify
// - Wait 10 us before program-verify
// - Failed program retries, 25 max
// - Write needs select, strobe low, gate high
// - Auto-select: high voltage line, code line
// - Erase setup and erase both use 20h
`timescale 1ns/1ps
`default_nettype none

module bfc_host
  import bfc_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_PULSE_CYC,
  parameter int PROG_CYC = PROG_PULSE_CYC,
  parameter logic [ADDR_W-1:0] LAST_ADDR = 17'h1ffff
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire bfc_pkg::bfc_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output bfc_pkg::bfc_rsp_t rsp,
  output logic rsp_valid,
  input wire logic [7:0] dq_i,
  output bfc_pkg::bfc_pins_t pins
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_WR_LO, S_WR_HI, S_RD_LO, S_RD_HI, S_WAIT, S_NEXT, S_DONE
  } bfc_st_t;

  // Which step of the flow a finished bus cycle belongs to
  typedef enum logic [3:0] {
    P_READ, P_IDENT, P_PSET, P_PWR, P_PVER, P_PCHK, P_ZSET, P_ZWR, P_ZVER, P_ZCHK,
    P_ESET, P_EWR, P_EVER, P_ECHK, P_RESET
  } bfc_ph_t;

  typedef struct packed {
    bfc_st_t st;
    bfc_ph_t ph;
    bfc_op_t op;
    logic [TMR_W-1:0] tmr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [9:0] tries;
    logic ready;
    logic rvalid;
    bfc_rsp_t rsp;
    bfc_pins_t pins;
  } bfc_state_t;

  bfc_state_t cur_ff; // Registered state
  bfc_state_t nxt_cur; // Next state

  // Start a write bus cycle with a given byte
  function automatic bfc_state_t start_wr(bfc_state_t s, logic [7:0] b, bfc_ph_t p);
    bfc_state_t r;
    r = s;
    r.pins.dq_o = b;
    r.pins.dq_oe = 1'b1;
    r.pins.out_gate_n = 1'b1;
    r.ph = p;
    r.tmr = '0;
    r.st = S_WR_LO;
    return r;
  endfunction : start_wr

  // Start a read bus cycle
  function automatic bfc_state_t start_rd(bfc_state_t s, bfc_ph_t p);
    bfc_state_t r;
    r = s;
    r.pins.dq_oe = 1'b0;
    r.ph = p;
    r.tmr = '0;
    r.st = S_RD_LO;
    return r;
  endfunction : start_rd

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rvalid = 1'b0;
    case (cur_ff.st)
      // Accept a request and raise the program supply for program or erase
      S_IDLE: begin
        nxt_cur.ready = 1'b1;
        nxt_cur.pins.id_hv_en = 1'b0;
        if (req_valid && cur_ff.ready) begin
          nxt_cur.ready = 1'b0;
          nxt_cur.op = req.op;
          nxt_cur.addr = req.addr;
          nxt_cur.data = req.data;
          nxt_cur.tries = '0;
          nxt_cur.pins.prog_supply_high_level = (req.op == OP_PROG) || (req.op == OP_ERASE);
          case (req.op)
            OP_PROG: nxt_cur = start_wr(nxt_cur, CMD_PROG, P_PSET);
            OP_ERASE: begin
              nxt_cur.addr = '0;
              nxt_cur = start_wr(nxt_cur, CMD_PROG, P_ZSET);
            end
            OP_IDENT: begin
              // Auto-select by pins with supply low: other addresses held low
              nxt_cur.pins.id_hv_en = 1'b1;
              nxt_cur.addr = {{(ADDR_W-1){1'b0}}, req.addr[0]};
              nxt_cur = start_rd(nxt_cur, P_IDENT);
            end
            default: nxt_cur = start_rd(nxt_cur, P_READ);
          endcase
        end
      end
      // Strobes low: address taken by the device at the later falling edge
      S_WR_LO: begin
        nxt_cur.pins.addr = cur_ff.addr;
        nxt_cur.pins.chip_sel_n = 1'b0;
        nxt_cur.pins.wr_strobe_n = 1'b0;
        nxt_cur.tmr = cur_ff.tmr + 1'b1;
        // Strobe held for several cycles, well past glitch width
        if (cur_ff.tmr == TMR_W'(STROBE_CYC)) begin
          nxt_cur.pins.wr_strobe_n = 1'b1;
          nxt_cur.tmr = '0;
          nxt_cur.st = S_WR_HI;
        end
      end
      // Strobe released: data latched on the rise, then deselect
      S_WR_HI: begin
        nxt_cur.pins.chip_sel_n = 1'b1;
        nxt_cur.pins.dq_oe = 1'b0;
        nxt_cur.tmr = '0;
        nxt_cur.st = S_NEXT;
        if (cur_ff.ph == P_EWR) nxt_cur.st = S_WAIT;
        if (cur_ff.ph == P_PWR || cur_ff.ph == P_ZWR) nxt_cur.st = S_WAIT;
      end
      // Read cycle: select and gate low, strobe high
      S_RD_LO: begin
        nxt_cur.pins.addr = cur_ff.addr;
        nxt_cur.pins.chip_sel_n = 1'b0;
        nxt_cur.pins.out_gate_n = 1'b0;
        nxt_cur.tmr = cur_ff.tmr + 1'b1;
        if (cur_ff.tmr == TMR_W'(STROBE_CYC)) begin
          nxt_cur.rsp.data = dq_i;
          nxt_cur.st = S_RD_HI;
        end
      end
      S_RD_HI: begin
        nxt_cur.pins.chip_sel_n = 1'b1;
        nxt_cur.pins.out_gate_n = 1'b1;
        nxt_cur.st = S_NEXT;
      end
      // Pulse wait; the verify command written next ends the pulse
      S_WAIT: begin
        nxt_cur.tmr = cur_ff.tmr + 1'b1;
        if (cur_ff.ph == P_EWR && cur_ff.tmr >= TMR_W'(ERASE_CYC - 1)) nxt_cur.st = S_NEXT;
        if (cur_ff.ph != P_EWR && cur_ff.tmr >= TMR_W'(PROG_CYC - 1)) nxt_cur.st = S_NEXT;
      end
      // Sequencing of command steps
      S_NEXT: begin
        case (cur_ff.ph)
          P_READ, P_IDENT: begin
            nxt_cur.rsp.ok = 1'b1;
            nxt_cur.rsp.fail = 1'b0;
            nxt_cur.st = S_DONE;
          end
          P_PSET: nxt_cur = start_wr(cur_ff, cur_ff.data, P_PWR);
          P_ZSET: nxt_cur = start_wr(cur_ff, ZERO_BYTE, P_ZWR);
          P_PWR: nxt_cur = start_wr(cur_ff, CMD_PROG_VERIFY, P_PVER);
          P_ZWR: nxt_cur = start_wr(cur_ff, CMD_PROG_VERIFY, P_ZVER);
          P_PVER: nxt_cur = start_rd(cur_ff, P_PCHK);
          P_ZVER: nxt_cur = start_rd(cur_ff, P_ZCHK);
          P_PCHK, P_ZCHK: begin
            nxt_cur.tries = cur_ff.tries + 1'b1;
            if (cur_ff.rsp.data == ((cur_ff.ph == P_PCHK) ? cur_ff.data : ZERO_BYTE)) begin
              nxt_cur.tries = '0;
              if (cur_ff.ph == P_PCHK) begin
                nxt_cur.rsp.ok = 1'b1;
                nxt_cur.rsp.fail = 1'b0;
                nxt_cur = start_wr(nxt_cur, CMD_READ, P_RESET);
              end else if (cur_ff.addr == LAST_ADDR) begin
                nxt_cur.addr = '0;
                nxt_cur = start_wr(nxt_cur, CMD_ERASE, P_ESET);
              end else begin
                nxt_cur.addr = cur_ff.addr + 1'b1;
                nxt_cur = start_wr(nxt_cur, CMD_PROG, P_ZSET);
              end
            end else if (cur_ff.tries >= 10'(MAX_PROG_TRIES - 1)) begin
              nxt_cur.rsp.ok = 1'b0;
              nxt_cur.rsp.fail = 1'b1;
              nxt_cur = start_wr(nxt_cur, CMD_READ, P_RESET);
            end else begin
              nxt_cur = start_wr(nxt_cur, CMD_PROG, (cur_ff.ph == P_PCHK) ? P_PSET : P_ZSET);
            end
          end
          P_ESET: nxt_cur = start_wr(cur_ff, CMD_ERASE, P_EWR);
          P_EWR: nxt_cur = start_wr(cur_ff, CMD_ERASE_VERIFY, P_EVER);
          P_EVER: nxt_cur = start_rd(cur_ff, P_ECHK);
          P_ECHK: begin
            if (cur_ff.rsp.data == ERASED_BYTE) begin
              if (cur_ff.addr == LAST_ADDR) begin
                nxt_cur.rsp.ok = 1'b1;
                nxt_cur.rsp.fail = 1'b0;
                nxt_cur = start_wr(nxt_cur, CMD_READ, P_RESET);
              end else begin
                nxt_cur.addr = cur_ff.addr + 1'b1;
                nxt_cur = start_wr(nxt_cur, CMD_ERASE_VERIFY, P_EVER);
              end
            end else if (cur_ff.tries >= 10'(MAX_ERASE_TRIES - 1)) begin
              nxt_cur.rsp.ok = 1'b0;
              nxt_cur.rsp.fail = 1'b1;
              nxt_cur = start_wr(nxt_cur, CMD_READ, P_RESET);
            end else begin
              // Repeat erase, resuming verify at the failing address
              nxt_cur.tries = cur_ff.tries + 1'b1;
              nxt_cur = start_wr(nxt_cur, CMD_ERASE, P_ESET);
            end
          end
          P_RESET: nxt_cur.st = S_DONE;
          default: nxt_cur.st = S_DONE;
        endcase
      end
      // Report and drop the program supply
      S_DONE: begin
        nxt_cur.pins.prog_supply_high_level = 1'b0;
        nxt_cur.pins.id_hv_en = 1'b0;
        nxt_cur.rvalid = 1'b1;
        nxt_cur.st = S_IDLE;
      end
      default: nxt_cur.st = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // State register; select, gate and write strobe idle high at reset, other pins low
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
      cur_ff.st <= S_IDLE;
      cur_ff.pins.chip_sel_n <= 1'b1;
      cur_ff.pins.out_gate_n <= 1'b1;
      cur_ff.pins.wr_strobe_n <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign req_ready = cur_ff.ready;
  assign rsp = cur_ff.rsp;
  assign rsp_valid = cur_ff.rvalid;
  assign pins = cur_ff.pins;

endmodule : bfc_host

`default_nettype wire

//--- bench/bfc_host_sva.sv
// Port checker for the flash host controller.
// Assumes a bind onto bfc_host and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bfc_host_chk
  import bfc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire bfc_pkg::bfc_req_t req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire bfc_pkg::bfc_rsp_t rsp,
  input wire logic rsp_valid,
  input wire logic [7:0] dq_i,
  input wire bfc_pkg::bfc_pins_t pins
);
  // ---------------------------------------------------------------
  // Write, read, auto-select and handshake checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Strobe held low through the whole cycle: STROBE_CYC clocks
  sequence s_wr_low;
    (!pins.wr_strobe_n)[*4];
  endsequence
  // Strobe rises first, select follows
  sequence s_wr_end;
    pins.wr_strobe_n ##1 pins.chip_sel_n;
  endsequence
  chk_strobe_len: assert property (
    $fell(pins.wr_strobe_n) |-> s_wr_low ##1 s_wr_end) else $error("short write strobe");
  chk_write_gate: assert property (
    !pins.wr_strobe_n |-> !pins.chip_sel_n && pins.out_gate_n && pins.dq_oe) else $error("bad write gating");
  chk_write_supply: assert property (
    !pins.wr_strobe_n |-> pins.prog_supply_high_level) else $error("write with low supply");
  chk_read_gate: assert property (
    !pins.out_gate_n |-> !pins.dq_oe && pins.wr_strobe_n) else $error("bus contention");
  chk_hold_addr: assert property (
    !pins.wr_strobe_n && !$fell(pins.wr_strobe_n) |-> $stable(pins.addr) && $stable(pins.dq_o))
    else $error("address or data moved in write");
  chk_ident_mode: assert property (
    pins.id_hv_en |-> !pins.prog_supply_high_level && pins.wr_strobe_n) else $error("bad auto-select");
  chk_take_once: assert property (
    req_valid && req_ready |=> !req_ready) else $error("ready stayed high");
  chk_rsp_pulse: assert property (
    rsp_valid |=> !rsp_valid ##[0:1] req_ready) else $error("bad completion pulse");
  chk_ok_xor: assert property (
    rsp_valid |-> rsp.ok != rsp.fail) else $error("ok and fail disagree");
endmodule : bfc_host_chk
`default_nettype wire

//--- bench/bfc_flash_model.sv
// Behavioural model of the bulk-erase flash, four bytes deep.
// Assumes pins change only at clk edges.
`timescale 1ns/1ps
`default_nettype none
module bfc_flash_model
  import bfc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire bfc_pkg::bfc_pins_t pins,
  input wire logic [7:0] stuck,
  output logic [7:0] dq
);
  localparam logic [7:0] MFR_ID = 8'h3c; // Arbitrary value
  localparam logic [7:0] DEV_ID = 8'hc3; // Arbitrary value
  logic [7:0] mem [4];
  logic [7:0] vbyte, last;
  logic [2:0] md; // 0 read, 1 erase staged, 3 program staged, 4 verify, 5 ident
  logic [1:0] pa;
  logic zeroed;
  logic armed; // Write strobe seen high since power-up
  int nprog, nerase;
  bfc_pins_t q;
  // Write accepted at strobe rise, supply high, gate high
  wire logic wr = !q.wr_strobe_n && pins.wr_strobe_n && !q.chip_sel_n && q.out_gate_n
    && q.prog_supply_high_level && armed;
  // Command state machine
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      md <= 3'h0;
      armed <= 1'b0;
      q <= '1;
      last <= 8'h00;
      mem <= '{8'hf0, 8'hf1, 8'hf2, 8'hf3};
      nprog <= 0;
      nerase <= 0;
      pa <= 2'h0;
    end else begin
      q <= pins;
      last <= dq;
      // A strobe held low since power-up never yields a command
      if (pins.wr_strobe_n && q.wr_strobe_n) begin
        armed <= 1'b1;
      end
      if (wr) begin
        case (md)
          3'h1: begin
            if (q.dq_o == CMD_ERASE) begin
              zeroed <= (mem[0] | mem[1] | mem[2] | mem[3]) == 8'h00;
              mem <= '{default: 8'hff};
              nerase <= nerase + 1;
            end
            md <= 3'h0;
          end
          3'h3: begin
            mem[q.addr[1:0]] <= mem[q.addr[1:0]] & (q.dq_o | stuck);
            pa <= q.addr[1:0];
            nprog <= nprog + 1;
            md <= 3'h0;
          end
          default: begin
            md <= q.dq_o == CMD_ERASE ? 3'h1 : q.dq_o == CMD_PROG ? 3'h3 : q.dq_o == CMD_AUTOSEL ? 3'h5
              : (q.dq_o == CMD_ERASE_VERIFY || q.dq_o == CMD_PROG_VERIFY) ? 3'h4 : 3'h0;
            vbyte <= q.dq_o == CMD_ERASE_VERIFY ? mem[q.addr[1:0]] : mem[pa];
          end
        endcase
      end
    end
  end
  // Output drive only with select and gate low, else a changing value
  always_comb begin
    if (!pins.chip_sel_n && !pins.out_gate_n) begin
      dq = (pins.id_hv_en || md == 3'h5) ? (pins.addr[0] ? DEV_ID : MFR_ID)
        : md == 3'h4 ? vbyte : mem[pins.addr[1:0]];
    end else begin
      dq = ~last;
    end
  end
endmodule : bfc_flash_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the flash host controller.
// Assumes the flash model and checker files compile first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bfc_pkg::*;
  logic clk, sys_rst, req_valid, req_ready, rsp_valid;
  logic [7:0] dq_i, stuck;
  bfc_req_t req;
  bfc_rsp_t rsp;
  bfc_pins_t pins;
  int fails, n_tests;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  bfc_host #(.ERASE_CYC(20), .PROG_CYC(5), .LAST_ADDR(17'h3)) dut (.clk(clk), .sys_rst(sys_rst),
    .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp(rsp), .rsp_valid(rsp_valid),
    .dq_i(dq_i), .pins(pins));
  bfc_flash_model fm (.clk(clk), .sys_rst(sys_rst), .pins(pins), .stuck(stuck), .dq(dq_i));
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  // One request, bounded waits for take and completion
  task op(input bfc_op_t o, input logic [16:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    req <= '{o, a, d};
    req_valid <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (req_ready !== 1'b1 && k < 50);
    req_valid <= 1'b0;
    if (req_ready !== 1'b1) begin
      fails++;
      summarize();
    end
    k = 0;
    do begin @(posedge clk); k++; end while (rsp_valid !== 1'b1 && k < 9000);
    if (rsp_valid !== 1'b1) begin
      fails++;
      summarize();
    end
  endtask : op
  task t_read;
    op(OP_READ, 17'h2, 8'h00);
    chk8("read", 8'hf2, rsp.data);
    $display("read done");
  endtask : t_read
  task t_ident;
    for (int i = 0; i < 2; i++) begin
      op(OP_IDENT, 17'(i), 8'h00);
      chk8("ident", i ? fm.DEV_ID : fm.MFR_ID, rsp.data);
    end
    $display("ident done");
  endtask : t_ident
  task t_prog;
    op(OP_PROG, 17'h1, 8'h30);
    chk8("prog ok", 8'h1, {7'h0, rsp.ok});
    chk8("prog cell", 8'h30, fm.mem[1]);
    $display("program done");
  endtask : t_prog
  task t_prog_fail;
    int n0;
    n0 = fm.nprog;
    stuck <= 8'h01;
    op(OP_PROG, 17'h3, 8'h00);
    chk8("prog fail", 8'h1, {7'h0, rsp.fail});
    chk8("prog tries", 8'd25, 8'(fm.nprog - n0));
    stuck <= 8'h00;
    $display("program retry done");
  endtask : t_prog_fail
  task t_erase;
    op(OP_ERASE, 17'h0, 8'h00);
    chk8("erase ok", 8'h1, {7'h0, rsp.ok});
    chk8("zeroed first", 8'h1, {7'h0, fm.zeroed});
    chk8("erase count", 8'h1, 8'(fm.nerase));
    for (int i = 0; i < 4; i++) chk8("erased", 8'hff, fm.mem[i]);
    op(OP_READ, 17'h0, 8'h00);
    chk8("read after erase", 8'hff, rsp.data);
    $display("erase done");
  endtask : t_erase
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    stuck = 8'h00;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_read();
    t_ident();
    t_prog();
    t_prog_fail();
    t_erase();
    summarize();
  end
endmodule : testbench
bind bfc_host bfc_host_chk u_chk (.clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
  .req_ready(req_ready), .rsp(rsp), .rsp_valid(rsp_valid), .dq_i(dq_i), .pins(pins));
`default_nettype wire
